// [inc/css_defines.vh]
// constants for the carrier sparing and status block
`ifndef CSS_DEFINES_VH
`define CSS_DEFINES_VH
`define CSS_ADDR_CTRL 8'h00
`define CSS_ADDR_STATUS 8'h04
`define CSS_ADDR_DISPLAY 8'h08
`define CSS_ADDR_HCOUNT 8'h0C
`define CSS_ADDR_EVENT 8'h10
`define CSS_ADDR_HIST 8'h40
`define CSS_HIST_DEPTH 16
`define CSS_CTRL_SPARE_CFG 0
`define CSS_CTRL_ENABLE 1
`define CSS_CTRL_ALM_DIS 2
`define CSS_CTRL_CAR_TEST 3
`define CSS_CTRL_SELFTEST 4
`define CSS_CTRL_EQUIP_LO 5
`define CSS_CTRL_ROLE 8
`define CSS_CTRL_HCLEAR 9
`define CSS_CTRL_RESET 10'h0E0
`define CSS_SEL_NONE 2'h0
`define CSS_SEL_LINK0 2'h1
`define CSS_SEL_LINK1 2'h2
`define CSS_RESP_OKAY 2'h0
`define CSS_RESP_SLVERR 2'h2
`define CSS_CLK_MHZ 125
`define CSS_BLINK_MS 250
`define CSS_BLINK_STEPS 3'h6
`endif

// [rtl/css_top.v]
// carrier sparing, indicators, self-test and display history with axi4-lite registers
// Behaviour
// - sparing works only when link 2 is configured as the spare.
// - with links 0 and 1 both faulty, the spare covers link 0.
// - link 1 fails, link 0 healthy, spare free: spare covers link 1.
// - link 0 failing while link 1 spared drops link 1, spare takes link 0.
// - when link 0 recovers with link 1 still faulty, spare returns to link 1.
// - a recovered spared link carries its calls on its own primary again.
// - self-test blinks card indicator three times on pass, steady otherwise; off when enabled.
// - carrier indicator lit while faulty at either end, dark when working or unequipped.
// - far-end alarms exchanged only while the in-band management link is up.
// - maintenance indicator lit for carrier tests, alarms disabled, or wrong role switch.
// - self-test runs on insertion, enable, reset and software command.
// - remote card keeps the last sixteen display codes; readable and clearable.
// - faceplate service switch enables carrier clocking without software enable.
// - local major alarm raises near-site message; remote major alarm raises far-site message.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "css_defines.vh"
module css_top #(
  parameter BLINK_CYCLES = `CSS_BLINK_MS * `CSS_CLK_MHZ * 1000
)(
  input wire clk,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] local_fault,
  input wire [2:0] far_fault_rx,
  input wire option_switch_bank,
  input wire faceplate_service_switch,
  input wire card_seated,
  input wire selftest_ok,
  input wire major_alarm_local,
  input wire major_alarm_remote,
  output reg [2:0] far_fault_tx,
  output reg spare_for_link0,
  output reg spare_for_link1,
  output reg card_led,
  output reg [2:0] carrier_led,
  output reg maint_led,
  output reg carrier_clock_enable,
  output reg [7:0] display_code,
  output reg near_site_alarm_message,
  output reg far_site_alarm_message
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;
  // two-flop synchronisers for every pin input
  reg [11:0] sync_a;
  reg [11:0] sync_b;
  wire [11:0] pins = {major_alarm_remote, major_alarm_local, selftest_ok, card_seated,
    faceplate_service_switch, option_switch_bank, far_fault_rx, local_fault};
  wire [2:0] loc_f = sync_b[2:0];
  wire [2:0] far_raw = sync_b[5:3];
  wire role_sw = sync_b[6];
  wire svc_sw = sync_b[7];
  wire seated = sync_b[8];
  wire test_ok = sync_b[9];
  reg [9:0] ctrl;
  reg [2:0] far_held;
  reg [1:0] spare_sel;
  reg preempt;
  reg seated_d;
  reg state;
  reg pass;
  reg [2:0] steps;
  reg [31:0] div;
  reg [3:0] wp;
  reg [4:0] hcount;
  reg [7:0] hist [0:`CSS_HIST_DEPTH-1];
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [1:0] next_sel;
  reg [31:0] rd;
  reg rd_ok;
  wire [2:0] equip = ctrl[7:5];
  wire [2:0] fault = (loc_f | far_held) & equip;
  wire link_up = |(equip & ~loc_f & ~far_raw); // live report avoids a latched-down link
  wire spare_ok = ctrl[`CSS_CTRL_SPARE_CFG] & ~fault[2];
  wire wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wr_ctrl = wr_go & (aw_addr == `CSS_ADDR_CTRL) & w_strb[0];
  wire wr_disp = wr_go & (aw_addr == `CSS_ADDR_DISPLAY) & w_strb[0];
  wire wr_event = wr_go & (aw_addr == `CSS_ADDR_EVENT) & w_strb[0];
  wire en_rise = wr_ctrl & w_data[`CSS_CTRL_ENABLE] & ~ctrl[`CSS_CTRL_ENABLE];
  wire test_cmd = wr_ctrl & w_data[`CSS_CTRL_SELFTEST];
  wire hclear = wr_ctrl & w_data[`CSS_CTRL_HCLEAR];
  wire tick = (div == BLINK_CYCLES - 1);
  wire test_start = en_rise | test_cmd | (seated & ~seated_d);
  wire [3:0] ridx = s_axi_araddr[5:2];
  wire [3:0] rslot = wp - 4'h1 - ridx;

  always @(posedge clk)
  begin
    sync_a <= pins;
    sync_b <= sync_a;
  end

  // spare choice: link 0 first, link 1 only when link 0 is healthy
  always @*
  begin
    next_sel = `CSS_SEL_NONE;
    if (spare_ok)
    begin
      if (fault[0])
        next_sel = `CSS_SEL_LINK0;
      else if (fault[1])
        next_sel = `CSS_SEL_LINK1;
    end
  end

  // sparing, indicators and alarm relay
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      far_held <= 3'h0;
      spare_sel <= `CSS_SEL_NONE;
      preempt <= 1'b0;
      seated_d <= seated; // no false insertion edge after reset
      far_fault_tx <= 3'h0;
      spare_for_link0 <= 1'b0;
      spare_for_link1 <= 1'b0;
      carrier_led <= 3'h0;
      maint_led <= 1'b0;
      carrier_clock_enable <= 1'b0;
      near_site_alarm_message <= 1'b0;
      far_site_alarm_message <= 1'b0;
    end
    else
    begin
      seated_d <= seated;
      // far status is stale while the management link is down, so keep the last copy
      if (link_up)
        far_held <= far_raw;
      far_fault_tx <= link_up ? (loc_f & equip) : 3'h0;
      spare_sel <= next_sel;
      spare_for_link0 <= (next_sel == `CSS_SEL_LINK0);
      spare_for_link1 <= (next_sel == `CSS_SEL_LINK1);
      // calls lost on link 1 when link 0 takes the spare; set wins over clear
      if ((spare_sel == `CSS_SEL_LINK1) && (next_sel == `CSS_SEL_LINK0))
        preempt <= 1'b1;
      else if (wr_event & w_data[0])
        preempt <= 1'b0;
      carrier_led <= fault;
      maint_led <= ctrl[`CSS_CTRL_CAR_TEST] | ctrl[`CSS_CTRL_ALM_DIS]
        | (role_sw != ctrl[`CSS_CTRL_ROLE]);
      carrier_clock_enable <= ctrl[`CSS_CTRL_ENABLE] | svc_sw;
      near_site_alarm_message <= sync_b[10];
      far_site_alarm_message <= sync_b[11];
    end
  end

  // self-test sequencer; starts from reset itself
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state <= ST_RUN;
      pass <= 1'b0;
      steps <= 3'h0;
      div <= 32'h0;
      card_led <= 1'b1;
    end
    else
    begin
      div <= (tick | test_start) ? 32'h0 : div + 32'h1;
      case (state)
        ST_IDLE:
        begin
          card_led <= ~ctrl[`CSS_CTRL_ENABLE];
          if (test_start)
          begin
            state <= ST_RUN;
            steps <= 3'h0;
            pass <= test_ok;
          end
        end
        ST_RUN:
        begin
          if (steps == 3'h0 && div == 32'h0)
            pass <= test_ok;
          card_led <= pass ? ~steps[0] : 1'b1;
          if (test_start)
            steps <= 3'h0;
          else if (tick)
          begin
            if (steps == `CSS_BLINK_STEPS - 3'h1)
              state <= ST_IDLE;
            steps <= steps + 3'h1;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // display history, kept only in the remote role
  genvar gi;
  generate
    for (gi = 0; gi < `CSS_HIST_DEPTH; gi = gi + 1)
    begin : g_hist
      always @(posedge clk)
      begin
        if (!rst_b || hclear)
          hist[gi] <= 8'h00;
        else if (wr_disp && role_sw && wp == gi)
          hist[gi] <= w_data[7:0];
      end
    end
  endgenerate

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      wp <= 4'h0;
      hcount <= 5'h00;
      display_code <= 8'h00;
    end
    else if (hclear)
    begin
      wp <= 4'h0;
      hcount <= 5'h00;
    end
    else if (wr_disp)
    begin
      display_code <= w_data[7:0];
      if (role_sw)
      begin
        wp <= wp + 4'h1;
        if (hcount != 5'h10)
          hcount <= hcount + 5'h01;
      end
    end
  end

  // register read mux
  always @*
  begin
    rd = 32'h0;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:6] == 2'h1)
      rd = {24'h0, hist[rslot]};
    else
      case (s_axi_araddr)
        `CSS_ADDR_CTRL: rd = {22'h0, 1'b0, ctrl[8:5], 1'b0, ctrl[3:0]};
        `CSS_ADDR_STATUS: rd = {19'h0, state, pass, card_led, maint_led, carrier_led,
          link_up, fault, spare_sel};
        `CSS_ADDR_DISPLAY: rd = {24'h0, display_code};
        `CSS_ADDR_HCOUNT: rd = {27'h0, hcount};
        `CSS_ADDR_EVENT: rd = {31'h0, preempt};
        default: rd_ok = 1'b0;
      endcase
  end

  // axi4-lite slave: address and data taken in any order, answer one cycle after both
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSS_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `CSS_RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      ctrl <= `CSS_CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == `CSS_ADDR_CTRL || aw_addr == `CSS_ADDR_DISPLAY
          || aw_addr == `CSS_ADDR_EVENT) ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
      end
      // command bits are pulses and are not stored
      if (wr_ctrl)
        ctrl <= {1'b0, w_data[8:5], 1'b0, w_data[3:0]};
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd;
        s_axi_rresp <= rd_ok ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// [verification/css_peer.sv]
// peer card model: reports its own carrier faults across the links
`timescale 1ns/100ps
module css_peer (
  input wire clk,
  input wire [2:0] peer_fault,
  input wire [2:0] far_fault_tx,
  output reg [2:0] far_fault_rx
);
  wire link_up;
  initial far_fault_rx = 3'h0;
  // some carrier good both ways carries the management link
  assign link_up = |(~peer_fault & ~far_fault_tx);
  // link down: no real report, so the lines churn rather than hold
  always @(posedge clk)
    far_fault_rx <= link_up ? peer_fault : ~far_fault_rx;
endmodule

// [verification/css_top_sva.sv]
// port assertions for the carrier sparing block
`timescale 1ns/100ps
module css_top_sva (
  input wire clk,
  input wire rst_b,
  input wire [2:0] local_fault,
  input wire [2:0] far_fault_rx,
  input wire faceplate_service_switch,
  input wire major_alarm_local,
  input wire major_alarm_remote,
  input wire [2:0] far_fault_tx,
  input wire spare_for_link0,
  input wire spare_for_link1,
  input wire [2:0] carrier_led,
  input wire carrier_clock_enable,
  input wire near_site_alarm_message,
  input wire far_site_alarm_message
);
  // inputs pass two sync flops, so four stable samples cover the delay; far_fault_rx also passes far_held and needs five
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_spare_one_link: assert property (!(spare_for_link0 && spare_for_link1))
    else $error("spare covers two links");
  a_link0_first: assert property ((local_fault[1:0] == 2'h3) [*4] |-> !spare_for_link1)
    else $error("link 1 spared over faulty link 0");
  a_spare_handback: assert property (
    (local_fault == 3'h0 && far_fault_rx == 3'h0) [*5] |-> !spare_for_link0 && !spare_for_link1)
    else $error("spare held after recovery");
  a_led_dark_ok: assert property (
    (local_fault == 3'h0 && far_fault_rx == 3'h0) [*5] |-> carrier_led == 3'h0)
    else $error("carrier led lit with no fault");
  a_link_down_quiet: assert property ((local_fault == 3'h7) [*4] |-> far_fault_tx == 3'h0)
    else $error("far faults sent with link down");
  a_service_clock: assert property (faceplate_service_switch [*4] |-> carrier_clock_enable)
    else $error("service switch left clocking off");
  a_near_alarm: assert property (major_alarm_local [*4] |-> near_site_alarm_message)
    else $error("near site alarm missing");
  a_far_alarm: assert property (
    $past(rst_b) && $past(major_alarm_remote, 3) && $past(major_alarm_remote, 4)
    |-> far_site_alarm_message)
    else $error("far site alarm missing");
endmodule
bind css_top css_top_sva u_sva (.clk, .rst_b, .local_fault, .far_fault_rx,
  .faceplate_service_switch, .major_alarm_local, .major_alarm_remote, .far_fault_tx,
  .spare_for_link0, .spare_for_link1, .carrier_led, .carrier_clock_enable,
  .near_site_alarm_message, .far_site_alarm_message);

// [verification/tb.sv]
// self-checking bench for the carrier sparing block
`timescale 1ns/100ps
`include "css_defines.vh"
module tb;
  reg clk = 1'h0;
  reg rst_b = 1'h0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg [2:0] lf = 3'h0, pf = 3'h0;
  reg opt = 1'h0, svc = 1'h0, seat = 1'h0, st_ok = 1'h1, mal = 1'h0, mar = 1'h0, cprev = 1'h0;
  wire awready, wready, bvalid, arready, rvalid, sp0, sp1, cled, mled, cce, nam, fam;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] ftx, frx, carled;
  wire [7:0] dcode;
  reg [31:0] got;
  reg [1:0] resp;
  integer err_count = 0, tests_run = 0, cyc = 0, falls = 0, i, done;
  localparam [14:0] FLT = {3'h6, 3'h0, 3'h2, 3'h3, 3'h2};
  localparam [9:0] SEL = {2'h0, 2'h0, 2'h2, 2'h1, 2'h2};
  localparam [39:0] CTL = {10'h0E1, 10'h1E1, 10'h0E9, 10'h0E5};
  css_top #(.BLINK_CYCLES(4)) DUT (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .local_fault(lf),
    .far_fault_rx(frx), .option_switch_bank(opt), .faceplate_service_switch(svc),
    .card_seated(seat), .selftest_ok(st_ok), .major_alarm_local(mal),
    .major_alarm_remote(mar), .far_fault_tx(ftx), .spare_for_link0(sp0),
    .spare_for_link1(sp1), .card_led(cled), .carrier_led(carled), .maint_led(mled),
    .carrier_clock_enable(cce), .display_code(dcode), .near_site_alarm_message(nam),
    .far_site_alarm_message(fam));
  css_peer u_peer (.clk(clk), .peer_fault(pf), .far_fault_tx(ftx), .far_fault_rx(frx));
  always #4 clk = ~clk;
  // falling edges of the card led count the blinks
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cprev === 1'h1 && cled === 1'h0)
      falls = falls + 1;
    cprev = cled;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // aw and w offered together, each dropped once taken
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      done = 0;
      while (done == 0)
      begin
        @(posedge clk);
        if (awready) awvalid <= 1'h0;
        if (wready) wvalid <= 1'h0;
        if (bvalid) done = 1;
      end
      bready <= 1'h0;
      chk(bresp, r);
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      done = 0;
      while (done == 0)
      begin
        @(posedge clk);
        if (arready) arvalid <= 1'h0;
        if (rvalid) done = 1;
      end
      rready <= 1'h0;
      got = rdata;
      resp = rresp;
    end
  endtask
  task blinks(input integer n);
    begin
      falls = 0;
      wt(40);
      chk(falls, n);
      chk(cled, 1'h0);
    end
  endtask
  initial
  begin
    wt(12);
    rst_b <= 1'h1;
    rd(`CSS_ADDR_CTRL);
    chk(got, 32'h0E0);
    rd(8'h3C);
    chk(resp, `CSS_RESP_SLVERR);
    svc <= 1'h1;
    wt(4);
    chk(cce, 1'h1);
    svc <= 1'h0;
    lf <= 3'h2;
    wt(4);
    chk(cce, 1'h0);
    rd(`CSS_ADDR_STATUS);
    chk(got[1:0], `CSS_SEL_NONE);
    wr(`CSS_ADDR_CTRL, 32'h0E1, `CSS_RESP_OKAY);
    for (i = 0; i < 5; i = i + 1)
    begin
      lf <= FLT[i*3+:3];
      wt(4);
      rd(`CSS_ADDR_STATUS);
      chk(got[1:0], SEL[i*2+:2]);
      chk({sp1, sp0}, SEL[i*2+:2]);
    end
    chk(carled, 3'h6);
    rd(`CSS_ADDR_EVENT);
    chk(got[0], 1'h1);
    wr(`CSS_ADDR_EVENT, 32'h1, `CSS_RESP_OKAY);
    rd(`CSS_ADDR_EVENT);
    chk(got[0], 1'h0);
    $display("test sparing done");
    lf <= 3'h0;
    pf <= 3'h1;
    wt(12);
    chk(carled, 3'h1);
    lf <= 3'h2;
    pf <= 3'h0;
    wt(8);
    chk(ftx, 3'h2);
    lf <= 3'h7;
    wt(8);
    chk(ftx, 3'h0);
    lf <= 3'h0;
    wt(8);
    chk(carled, 3'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`CSS_ADDR_CTRL, CTL[i*10+:10], `CSS_RESP_OKAY);
      wt(2);
      chk(mled, i < 3);
    end
    mal <= 1'h1;
    wt(4);
    chk({nam, fam}, 2'h2);
    mal <= 1'h0;
    mar <= 1'h1;
    wt(4);
    chk({nam, fam}, 2'h1);
    $display("test indicators done");
    wr(`CSS_ADDR_CTRL, 32'h0E3, `CSS_RESP_OKAY);
    blinks(3);
    st_ok <= 1'h0;
    wr(`CSS_ADDR_CTRL, 32'h0F3, `CSS_RESP_OKAY);
    blinks(1);
    st_ok <= 1'h1;
    seat <= 1'h1;
    blinks(3);
    $display("test self-test done");
    opt <= 1'h1;
    wr(`CSS_ADDR_CTRL, 32'h1E3, `CSS_RESP_OKAY);
    for (i = 1; i < 18; i = i + 1)
      wr(`CSS_ADDR_DISPLAY, i, `CSS_RESP_OKAY);
    chk(dcode, 8'h11);
    rd(`CSS_ADDR_HCOUNT);
    chk(got, 32'h10);
    rd(`CSS_ADDR_HIST);
    chk(got, 32'h11);
    rd(`CSS_ADDR_HIST + 8'h3C);
    chk(got, 32'h02);
    wr(`CSS_ADDR_HCOUNT, 32'h0, `CSS_RESP_SLVERR);
    wr(`CSS_ADDR_CTRL, 32'h3E3, `CSS_RESP_OKAY);
    rd(`CSS_ADDR_HCOUNT);
    chk(got, 32'h0);
    rd(`CSS_ADDR_HIST);
    chk(got, 32'h0);
    $display("test history done");
    wrap_up;
  end
endmodule
